// >>> rtl/pcr_pkg.sv
// Package for the PHY threshold and control register bank
package pcr_pkg;
   localparam int PCR_ADDR_W = 4;
   localparam int PCR_DATA_W = 16;
   localparam logic [3:0] PCR_IDX_THRESHOLD = 4'h2;
   localparam logic [3:0] PCR_IDX_CONTROL = 4'h3;
   localparam logic [15:0] PCR_THRESHOLD_RESET = 16'h0000;
   localparam logic [15:0] PCR_CONTROL_RESET = 16'h0000;
   localparam int PCR_BIT_RETRANSMIT = 0;
   localparam int PCR_BIT_ACK_SEND = 1;
   localparam int PCR_BIT_CLOCK_GATE = 2;
   localparam logic [31:0] PCR_UNMAPPED_READ = 32'h0000_0000;
   typedef enum logic [1:0] {PCR_IDLE, PCR_ANSWER} pcr_state_e;
endpackage

// >>> rtl/pcr_if.sv
// Write port bundle between bus slave and register store
`timescale 1ns/1ns
interface pcr_if;
   logic wr_thr;
   logic wr_ctl;
   logic [15:0] wdata;
   logic [15:0] thr;
   logic [15:0] ctl;
   modport store (input wr_thr, input wr_ctl, input wdata, output thr, output ctl);
   modport bus (output wr_thr, output wr_ctl, output wdata, input thr, input ctl);
endinterface

// >>> rtl/pcr_store.sv
// Threshold and control register storage with self-clearing strobes
`timescale 1ns/1ns
module pcr_store
   import pcr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   pcr_if.store rif
);
   logic [15:0] thr_reg;
   logic [15:0] ctl_reg;
   logic [15:0] ctl_next;
   logic [15:0] strobe_mask;

   assign strobe_mask = 16'h0003;
   // Strobes drop back one cycle after set; other bits keep their value
   assign ctl_next = rif.wr_ctl ? rif.wdata : (ctl_reg & ~strobe_mask);
   assign rif.thr = thr_reg;
   assign rif.ctl = ctl_reg;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         thr_reg <= PCR_THRESHOLD_RESET;
         ctl_reg <= PCR_CONTROL_RESET;
      end
      else if (ce_i)
      begin
         if (rif.wr_thr)
            thr_reg <= rif.wdata;
         ctl_reg <= ctl_next;
      end
   end
endmodule

// >>> rtl/pcr_regs.sv
// Avalon-MM register bank for channel threshold and PHY control
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ns
module pcr_regs
   import pcr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [15:0] estimation_threshold_value_o,
   output logic retransmit_strobe_o,
   output logic ack_send_strobe_o,
   output logic phy_clock_gate_enable_o
);
   pcr_if rif ();
   pcr_state_e state_reg;
   pcr_state_e state_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [15:0] thr_out_reg;
   logic retx_reg;
   logic ack_reg;
   logic gate_reg;
   logic req;
   logic idle;
   logic [3:0] word_idx;
   logic hit_thr;
   logic hit_ctl;
   logic [15:0] merged_thr;
   logic [15:0] merged_ctl;
   logic [15:0] lane_mask;

   pcr_store u_store (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .rif(rif)
   );

   // Byte address is four times the register index
   assign word_idx = avs_address_i[5:2];
   assign req = avs_read_i | avs_write_i;
   assign idle = (state_reg == PCR_IDLE);
   assign hit_thr = (word_idx == PCR_IDX_THRESHOLD) && (avs_address_i[1:0] == 2'h0);
   assign hit_ctl = (word_idx == PCR_IDX_CONTROL) && (avs_address_i[1:0] == 2'h0);
   assign lane_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   assign merged_thr = (avs_writedata_i[15:0] & lane_mask) | (rif.thr & ~lane_mask);
   assign merged_ctl = (avs_writedata_i[15:0] & lane_mask) | (rif.ctl & ~lane_mask);

   // Write takes effect in the idle cycle, answer follows one cycle later
   assign rif.wr_thr = ce_i && idle && avs_write_i && hit_thr;
   assign rif.wr_ctl = ce_i && idle && avs_write_i && hit_ctl;
   assign rif.wdata = hit_thr ? merged_thr : merged_ctl;

   assign rdata_next = hit_thr ? {16'h0000, rif.thr}
      : hit_ctl ? {16'h0000, rif.ctl} : PCR_UNMAPPED_READ;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         PCR_IDLE:
            if (req)
               state_next = PCR_ANSWER;
         PCR_ANSWER:
            state_next = PCR_IDLE;
         default:
            state_next = PCR_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_reg <= PCR_IDLE;
         rdata_reg <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         state_reg <= state_next;
         if (idle && avs_read_i)
            rdata_reg <= rdata_next;
      end
   end

   // Output copies registered so every top output is a flop
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         thr_out_reg <= PCR_THRESHOLD_RESET;
         retx_reg <= 1'b0;
         ack_reg <= 1'b0;
         gate_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         thr_out_reg <= rif.thr;
         retx_reg <= rif.ctl[PCR_BIT_RETRANSMIT];
         ack_reg <= rif.ctl[PCR_BIT_ACK_SEND];
         gate_reg <= rif.ctl[PCR_BIT_CLOCK_GATE];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         avs_waitrequest_o <= 1'b1;
      else if (ce_i)
         avs_waitrequest_o <= !(idle && req);
   end

   assign avs_readdata_o = rdata_reg;
   assign estimation_threshold_value_o = thr_out_reg;
   assign retransmit_strobe_o = retx_reg;
   assign ack_send_strobe_o = ack_reg;
   assign phy_clock_gate_enable_o = gate_reg;
endmodule

// >>> bench/pcr_regs_chk.sv
// Assertion checker for the threshold and control register bank
`timescale 1ns/1ns
module pcr_regs_chk (
   input logic clk_i,
   input logic rst_i,
   input logic ce_i,
   input logic [5:0] avs_address_i,
   input logic avs_read_i,
   input logic avs_write_i,
   input logic [31:0] avs_writedata_i,
   input logic [3:0] avs_byteenable_i,
   input logic avs_waitrequest_o,
   input logic [15:0] estimation_threshold_value_o,
   input logic retransmit_strobe_o,
   input logic ack_send_strobe_o,
   input logic phy_clock_gate_enable_o
);
   wire tk = ce_i & avs_waitrequest_o & (avs_read_i | avs_write_i);
   wire wc = tk & avs_write_i & (avs_address_i == 6'h0c) & avs_byteenable_i[0];
   wire wt = tk & avs_write_i & (avs_address_i == 6'h08);
   wire rt = retransmit_strobe_o;
   wire wr0 = wc & avs_writedata_i[0];
   wire ak = ack_send_strobe_o;
   wire [15:0] th = estimation_threshold_value_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_rt; wc & avs_writedata_i[0] |=> !rt ##1 rt ##1 !rt; endproperty
   a_rt: assert property (p_rt) else $error("retransmit pulse");
   property p_ak; wc & avs_writedata_i[1] |=> !ak ##1 ak ##1 !ak; endproperty
   a_ak: assert property (p_ak) else $error("ack pulse");
   property p_src; $rose(rt) |-> $past(wr0, 2); endproperty
   a_src: assert property (p_src) else $error("stray retransmit");
   property p_thr; wt && avs_byteenable_i[1:0] == 2'h3
      |=> ##1 th == $past(avs_writedata_i[15:0], 2); endproperty
   a_thr: assert property (p_thr) else $error("threshold value");
   property p_keep; $changed(th) |-> $past(wt, 2); endproperty
   a_keep: assert property (p_keep) else $error("threshold changed");
   property p_gate; wc
      |=> ##1 phy_clock_gate_enable_o == $past(avs_writedata_i[2], 2); endproperty
   a_gate: assert property (p_gate) else $error("clock gate");
   property p_wait; tk |=> !avs_waitrequest_o ##1 avs_waitrequest_o; endproperty
   a_wait: assert property (p_wait) else $error("waitrequest");
   property p_rst; $fell(rst_i) |-> th == 16'h0000 && !phy_clock_gate_enable_o; endproperty
   a_rst: assert property (p_rst) else $error("reset value");
endmodule

// >>> bench/pcr_regs_tb_top.sv
// Testbench for the threshold and control register bank
`timescale 1ns/1ns
module pcr_regs_tb_top;
   logic clk_i = 0, rst_i = 1, rd = 0, wr = 0, wq, wrq, rt, ack, gate;
   logic [5:0] a = 0;
   logic [31:0] d = 0, rdq, rdn, rdata;
   logic [3:0] be = 0;
   logic [15:0] thr;
   int error_cnt = 0, checks_done = 0, n_rt = 0, n_ack = 0;
   always #5 clk_i = ~clk_i;
   // Mid-cycle copies avoid racing the design at the edge
   always @(negedge clk_i)
   begin
      wq = wrq;
      rdn = rdata;
      n_rt += rt;
      n_ack += ack;
   end
   pcr_regs pcr_regs_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .avs_address_i(a),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(d), .avs_byteenable_i(be),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wrq), .estimation_threshold_value_o(thr),
      .retransmit_strobe_o(rt), .ack_send_strobe_o(ack), .phy_clock_gate_enable_o(gate));
   task automatic acc(input logic w, input logic [5:0] ad, input logic [31:0] dd,
      input logic [3:0] bb);
      wr <= w;
      rd <= !w;
      a <= ad;
      d <= dd;
      be <= bb;
      do @(posedge clk_i); while (wq !== 1'b0);
      // Read data taken from the copy made at the falling edge inside the answer cycle
      rdq = rdn;
      wr <= 0;
      rd <= 0;
      @(posedge clk_i);
   endtask
   task automatic chk(input string n, input logic [31:0] s, e);
      checks_done++;
      if (s !== e)
      begin
         error_cnt++;
         $display("Error %s: expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rc(input logic [5:0] ad, input logic [31:0] e);
      acc(0, ad, 0, 4'hf);
      chk("readdata", rdq, e);
   endtask
   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      #20000;
      error_cnt++;
      final_report;
   end
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      rc(6'h08, 0);
      rc(6'h0c, 0);
      $display("Reset test done");
      acc(1, 6'h08, 32'hbeef_a5c3, 4'hf);
      rc(6'h08, 32'ha5c3);
      chk("threshold", thr, 16'ha5c3);
      acc(1, 6'h08, 32'hffff, 4'h1);
      rc(6'h08, 32'ha5ff);
      acc(1, 6'h10, 32'h1, 4'hf);
      rc(6'h10, 0);
      rc(6'h08, 32'ha5ff);
      $display("Threshold test done");
      acc(1, 6'h0c, 32'h7, 4'h1);
      rc(6'h0c, 32'h4);
      chk("retransmit pulses", n_rt, 1);
      chk("ack pulses", n_ack, 1);
      chk("clock gate", gate, 1);
      acc(1, 6'h0c, 32'h0, 4'h1);
      chk("clock gate", gate, 0);
      chk("retransmit pulses", n_rt, 1);
      acc(1, 6'h0c, 32'h4, 4'h1);
      $display("Control test done");
      rst_i <= 1;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      rc(6'h08, 0);
      rc(6'h0c, 0);
      $display("Second reset test done");
      final_report;
   end
endmodule
bind pcr_regs pcr_regs_chk pcr_regs_chk_i (.*);
